// *** core/regulator_mfr_config_regs.sv ***
`timescale 1ns/10ps
`default_nettype none
module regulator_mfr_config_regs
  import regulator_cfg_pkg::*;
#(
  parameter int         TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES,
  parameter logic [6:0] DEV_ADDR       = DEV_ADDR_DEFAULT
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic [7:0] output_setpoint_command,
  input  wire logic [7:0] voltage_identification_inputs,
  input  wire logic       fault_request,
  input  wire logic       alert_request,
  output logic            fault_out,
  output logic            alert_out,
  output logic [2:0]      light_load_phases,
  output logic [2:0]      active_phase_count,
  output logic            digital_setpoint_select,
  output logic [7:0]      output_setpoint,
  output logic            monitor_enable,
  output logic            loop_test_enable,
  output logic            write_locked
);

  localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

  logic            busy, activity, wr_valid, timeout_abort;
  reg_wr_s         wr;
  logic [7:0]      rd_cmd, rd_data;
  logic            lock, next_lock;
  logic [7:0]      mfr_cfg, next_mfr_cfg;
  logic [7:0]      cfg_a, next_cfg_a;
  logic [7:0]      cfg_b, next_cfg_b;
  logic [TO_W-1:0] to_cnt, next_to_cnt;
  logic [7:0]      vid_meta, vid_sync;
  logic [2:0]      next_light_load, next_phase_count;
  logic [7:0]      next_setpoint;

  smbus_target #(
    .DEV_ADDR (DEV_ADDR)
  ) u_target (
    .mclk     (mclk),
    .rst_b    (rst_b),
    .scl_in   (scl_in),
    .sda_in   (sda_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .abort    (timeout_abort),
    .busy     (busy),
    .activity (activity),
    .wr_valid (wr_valid),
    .wr       (wr),
    .rd_cmd   (rd_cmd),
    .rd_data  (rd_data)
  );

  // Register writes
  always_comb begin
    next_lock    = lock;
    next_mfr_cfg = mfr_cfg;
    next_cfg_a   = cfg_a;
    next_cfg_b   = cfg_b;
    if (wr_valid) begin
      case (wr.cmd)
        CMD_LOCK_RESET: begin
          if (wr.data[SOFT_RESET_BIT] && !lock) begin
            next_mfr_cfg = MFR_RESET_VAL;
            next_cfg_a   = CFG_RESET_VAL;
            next_cfg_b   = CFG_RESET_VAL;
          end
          if (wr.data[LOCK_BIT]) begin
            next_lock = 1'b1;
          end
        end
        CMD_MFR_CONFIG: begin
          next_mfr_cfg = wr.data & MFR_RW_MASK;
          if (lock) begin
            next_mfr_cfg[MFR_TIMEOUT_BIT] = mfr_cfg[MFR_TIMEOUT_BIT];
          end
        end
        CMD_CONFIG_A: begin
          next_cfg_a = wr.data;
        end
        CMD_CONFIG_B: begin
          next_cfg_b = wr.data;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      lock    <= LOCK_RESET_VAL[LOCK_BIT];
      mfr_cfg <= MFR_RESET_VAL;
      cfg_a   <= CFG_RESET_VAL;
      cfg_b   <= CFG_RESET_VAL;
    end else begin
      lock    <= next_lock;
      mfr_cfg <= next_mfr_cfg;
      cfg_a   <= next_cfg_a;
      cfg_b   <= next_cfg_b;
    end
  end

  // Read data for the current command code
  always_comb begin
    case (rd_cmd)
      CMD_LOCK_RESET: rd_data = {7'h00, lock};
      CMD_MFR_CONFIG: rd_data = mfr_cfg;
      CMD_CONFIG_A:   rd_data = cfg_a;
      CMD_CONFIG_B:   rd_data = cfg_b;
      default:        rd_data = 8'h00;
    endcase
  end

  // Bus stall timeout
  assign timeout_abort = busy && mfr_cfg[MFR_TIMEOUT_BIT] &&
                         (to_cnt == TO_W'(TIMEOUT_CYCLES));

  always_comb begin
    if (!busy || activity || timeout_abort ||
        !mfr_cfg[MFR_TIMEOUT_BIT]) begin
      next_to_cnt = '0;
    end else begin
      next_to_cnt = to_cnt + TO_W'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      to_cnt <= '0;
    end else begin
      to_cnt <= next_to_cnt;
    end
  end

  // Decoded outputs
  always_comb begin
    case (mfr_cfg[MFR_LOAD_HI:MFR_LOAD_LO])
      2'b01:   next_light_load = 3'h2;
      2'b10:   next_light_load = 3'h3;
      default: next_light_load = 3'h1;
    endcase
    if (cfg_a[CFG_PHASE_HI:CFG_PHASE_LO] <= 3'h5) begin
      next_phase_count = cfg_a[CFG_PHASE_HI:CFG_PHASE_LO] + 3'h1;
    end else begin
      next_phase_count = 3'h6;
    end
    if (cfg_a[CFG_SETPOINT_BIT]) begin
      next_setpoint = output_setpoint_command;
    end else begin
      next_setpoint = vid_sync;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      vid_meta                <= 8'h00;
      vid_sync                <= 8'h00;
      light_load_phases       <= 3'h1;
      active_phase_count      <= 3'h1;
      output_setpoint         <= 8'h00;
      digital_setpoint_select <= 1'b0;
      fault_out               <= 1'b0;
      alert_out               <= 1'b0;
      monitor_enable          <= 1'b0;
      loop_test_enable        <= 1'b0;
      write_locked            <= 1'b0;
    end else begin
      vid_meta                <= voltage_identification_inputs;
      vid_sync                <= vid_meta;
      light_load_phases       <= next_light_load;
      active_phase_count      <= next_phase_count;
      output_setpoint         <= next_setpoint;
      digital_setpoint_select <= cfg_a[CFG_SETPOINT_BIT];
      fault_out   <= fault_request & mfr_cfg[MFR_FAULT_BIT];
      alert_out   <= alert_request & mfr_cfg[MFR_ALERT_BIT];
      monitor_enable <= mfr_cfg[MFR_MONITOR_BIT];
      loop_test_enable <= cfg_a[CFG_LOOP_BIT] &
                          cfg_b[CFG_LOOP_BIT];
      write_locked <= lock;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  a_soft_reset_defaults: assert property (
    wr_valid && wr.cmd == CMD_LOCK_RESET && wr.data[SOFT_RESET_BIT] &&
    !lock |=> mfr_cfg == MFR_RESET_VAL && cfg_a == CFG_RESET_VAL &&
    cfg_b == CFG_RESET_VAL)
    else $error("soft reset did not restore defaults");

  a_reset_when_locked: assert property (
    wr_valid && wr.cmd == CMD_LOCK_RESET && lock
    |=> $stable(mfr_cfg) && $stable(cfg_a) && $stable(cfg_b))
    else $error("soft reset acted while locked");

  a_lock_stays_set: assert property (
    lock |=> lock ##1 write_locked)
    else $error("write-protect latch cleared");

  a_light_load_map: assert property (
    mfr_cfg[MFR_LOAD_HI:MFR_LOAD_LO] == 2'b11 |=> light_load_phases == 3'h1)
    else $error("light-load code 11 not one phase");

  a_timeout_release: assert property (
    timeout_abort |=> !busy && !sda_oe)
    else $error("bus not released after timeout");

  a_timeout_bit_lock: assert property (
    lock && wr_valid && wr.cmd == CMD_MFR_CONFIG
    |=> $stable(mfr_cfg[MFR_TIMEOUT_BIT]))
    else $error("locked timeout enable changed");

  a_fault_gated: assert property (
    !mfr_cfg[MFR_FAULT_BIT] |=> !fault_out)
    else $error("fault pin asserted while disabled");

  a_alert_gated: assert property (
    alert_out |-> $past(mfr_cfg[MFR_ALERT_BIT]) && $past(alert_request))
    else $error("alert pin asserted while disabled");

  a_monitor_follow: assert property (
    $rose(mfr_cfg[MFR_MONITOR_BIT]) |=> monitor_enable)
    else $error("monitor enable not followed");

  a_phase_overflow: assert property (
    cfg_a[CFG_PHASE_HI:CFG_PHASE_LO] > 3'h5 |=> active_phase_count == 3'h6)
    else $error("out of range phase code not six");

  a_setpoint_source: assert property (
    cfg_a[CFG_SETPOINT_BIT]
    |=> output_setpoint == $past(output_setpoint_command))
    else $error("setpoint not from command register");

  a_loop_needs_both: assert property (
    loop_test_enable |-> $past(cfg_a[CFG_LOOP_BIT] && cfg_b[CFG_LOOP_BIT]))
    else $error("loop test enabled without both bits");

endmodule : regulator_mfr_config_regs
`default_nettype wire

// *** core/regulator_cfg_pkg.sv ***
// Notes on behaviour
// - Writing one to bit 1 of the lock and reset register restores the manufacturer, configuration A and B registers to their power-on values.
// - That soft reset is ignored while the write-protect latch is set.
// - Writing one to bit 0 sets a write-protect latch that only power-on reset clears.
// - Bits 7:6 of the manufacturer register pick the light-load phase count: 00=1, 01=2, 10=3, 11=1.
// - With bus timeout enabled, a transaction to us that stalls over 35 ms makes us release the bus.
// - The bus timeout enable bit is lockable and frozen once the latch is set.
// - Bit 2 of the manufacturer register gates the fault pin and resets to one.
// - Bit 1 of the manufacturer register gates the alert pin, which asserts only while it is one.
// - Bit 0 of the manufacturer register turns on converter sampling and monitoring.
// - Bits 6:4 of configuration A give the phase count, 000..101 = 1..6, other codes = 6.
// - Bit 3 of configuration A takes the setpoint from the command register, else from the pins.
// - Loop test mode is on only when bit 2 is set in both configuration A and B.
// - Configuration B shares the layout of A and dual functions need the bit in both.
package regulator_cfg_pkg;

  localparam logic [7:0] CMD_LOCK_RESET = 8'hD0;
  localparam logic [7:0] CMD_MFR_CONFIG = 8'hD1;
  localparam logic [7:0] CMD_CONFIG_A   = 8'hD2;
  localparam logic [7:0] CMD_CONFIG_B   = 8'hD3;

  localparam logic [7:0] LOCK_RESET_VAL = 8'h00;
  localparam logic [7:0] MFR_RESET_VAL  = 8'h07;
  localparam logic [7:0] CFG_RESET_VAL  = 8'h52;
  localparam logic [7:0] MFR_RW_MASK    = 8'hCF;

  localparam int LOCK_BIT        = 0;
  localparam int SOFT_RESET_BIT  = 1;
  localparam int MFR_LOAD_HI     = 7;
  localparam int MFR_LOAD_LO     = 6;
  localparam int MFR_TIMEOUT_BIT = 3;
  localparam int MFR_FAULT_BIT   = 2;
  localparam int MFR_ALERT_BIT   = 1;
  localparam int MFR_MONITOR_BIT = 0;
  localparam int CFG_PHASE_HI    = 6;
  localparam int CFG_PHASE_LO    = 4;
  localparam int CFG_SETPOINT_BIT = 3;
  localparam int CFG_LOOP_BIT    = 2;

  localparam int BUS_TIMEOUT_MS     = 35;
  localparam int MCLK_KHZ           = 100000;
  localparam int BUS_TIMEOUT_CYCLES = BUS_TIMEOUT_MS * MCLK_KHZ;

  // Arbitrary bus address
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20;
  localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
  localparam logic [1:0] DATA_INDEX       = 2'h2;

  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] data;
  } reg_wr_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RX   = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TX   = 5'b01000,
    ST_RACK = 5'b10000
  } target_state_e;

endpackage : regulator_cfg_pkg

// *** core/smbus_target.sv ***
`timescale 1ns/10ps
`default_nettype none
module smbus_target
  import regulator_cfg_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input  wire logic       mclk,
  input  wire logic       rst_b,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       abort,
  output logic            busy,
  output logic            activity,
  output logic            wr_valid,
  output reg_wr_s         wr,
  output logic [7:0]      rd_cmd,
  input  wire logic [7:0] rd_data
);

  logic          scl_meta, scl_sync, scl_prev;
  logic          sda_meta, sda_sync, sda_prev;
  logic          start, stop, rise, fall;
  target_state_e state, next_state;
  logic [7:0]    sh, next_sh, next_cmd;
  logic [3:0]    cnt, next_cnt;
  logic [1:0]    idx, next_idx;
  logic          rd_mode, next_rd_mode;
  logic          next_sda_oe, next_wr_valid;
  reg_wr_s       next_wr;

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_meta <= scl_in;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  assign start    = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop     = scl_sync & scl_prev & ~sda_prev & sda_sync;
  assign rise     = scl_sync & ~scl_prev;
  assign fall     = ~scl_sync & scl_prev;
  assign activity = rise | fall | start | stop;
  assign busy     = (state != ST_IDLE);
  assign sda_out  = 1'b0;

  always_comb begin
    next_state    = state;
    next_sh       = sh;
    next_cnt      = cnt;
    next_idx      = idx;
    next_rd_mode  = rd_mode;
    next_cmd      = rd_cmd;
    next_sda_oe   = sda_oe;
    next_wr_valid = 1'b0;
    next_wr       = wr;
    if (abort || stop) begin
      next_state  = ST_IDLE;
      next_sda_oe = 1'b0;
    end else if (start) begin
      next_state  = ST_RX;
      next_cnt    = 4'h0;
      next_idx    = 2'h0;
      next_sda_oe = 1'b0;
    end else begin
      case (state)
        ST_RX: begin
          if (rise) begin
            next_sh  = {sh[6:0], sda_sync};
            next_cnt = cnt + 4'h1;
          end else if (fall && cnt == BITS_PER_BYTE) begin
            next_cnt    = 4'h0;
            next_state  = ST_ACK;
            next_sda_oe = 1'b1;
            if (idx == 2'h0) begin
              next_rd_mode = sh[0];
              if (sh[7:1] != DEV_ADDR) begin
                next_state  = ST_IDLE;
                next_sda_oe = 1'b0;
              end
            end else if (idx == 2'h1) begin
              next_cmd = sh;
            end else begin
              next_wr_valid = 1'b1;
              next_wr       = '{cmd: rd_cmd, data: sh};
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            next_idx = (idx == DATA_INDEX) ? DATA_INDEX : idx + 2'h1;
            if (rd_mode) begin
              next_sh     = rd_data;
              next_sda_oe = ~rd_data[7];
              next_cnt    = 4'h1;
              next_state  = ST_TX;
            end else begin
              next_sda_oe = 1'b0;
              next_state  = ST_RX;
            end
          end
        end
        ST_TX: begin
          if (fall) begin
            if (cnt == BITS_PER_BYTE) begin
              next_sda_oe = 1'b0;
              next_state  = ST_RACK;
            end else begin
              next_sh     = {sh[6:0], 1'b0};
              next_sda_oe = ~sh[6];
              next_cnt    = cnt + 4'h1;
            end
          end
        end
        ST_RACK: begin
          if (rise && sda_sync) begin
            next_state = ST_IDLE;
          end else if (fall) begin
            next_sh     = rd_data;
            next_sda_oe = ~rd_data[7];
            next_cnt    = 4'h1;
            next_state  = ST_TX;
          end
        end
        default: begin
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      sh       <= 8'h00;
      cnt      <= 4'h0;
      idx      <= 2'h0;
      rd_mode  <= 1'b0;
      rd_cmd   <= 8'h00;
      sda_oe   <= 1'b0;
      wr_valid <= 1'b0;
      wr       <= '0;
    end else begin
      state    <= next_state;
      sh       <= next_sh;
      cnt      <= next_cnt;
      idx      <= next_idx;
      rd_mode  <= next_rd_mode;
      rd_cmd   <= next_cmd;
      sda_oe   <= next_sda_oe;
      wr_valid <= next_wr_valid;
      wr       <= next_wr;
    end
  end

endmodule : smbus_target
`default_nettype wire

// *** verif/smbus_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module smbus_host_model
  import regulator_cfg_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  sda,
  output logic       scl,
  output logic       sda_low,
  output logic       rd_valid,
  output logic [7:0] rd_byte,
  output logic       nacked
);
  initial begin
    scl      = 1'b1;
    sda_low  = 1'b0;
    rd_valid = 1'b0;
    rd_byte  = 8'h00;
    nacked   = 1'b0;
  end
  // Half of a bus bit, at least four clocks per phase
  task automatic half();
    repeat (8) @(posedge mclk);
    #1;
  endtask : half
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    half();
    scl = 1'b1;
    half();
    s = sda;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    sda_low = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b1;
    half();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_low = 1'b0;
    half();
  endtask : stop
  task automatic xfer(input logic [7:0] d, input logic ab,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(ab, a);
  endtask : xfer
  // Byte out, device must acknowledge
  task automatic put(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    xfer(d, 1'b1, q, a);
    if (a !== 1'b0) begin
      nacked = 1'b1;
    end
  endtask : put
  task automatic open_addr();
    logic s;
    start();
    for (int i = 7; i >= 0; i--) begin
      bit_io(DEV_ADDR_DEFAULT_BIT(i), s);
    end
  endtask : open_addr
  function automatic logic DEV_ADDR_DEFAULT_BIT(input int i);
    logic [7:0] a;
    a = {DEV_ADDR_DEFAULT, 1'b0};
    return a[i];
  endfunction : DEV_ADDR_DEFAULT_BIT
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    start();
    put({DEV_ADDR_DEFAULT, 1'b0});
    put(c);
    put(d);
    stop();
  endtask : wr
  // Single byte read closed by NACK
  task automatic rd(input logic [7:0] c);
    logic [7:0] q;
    logic       a;
    start();
    put({DEV_ADDR_DEFAULT, 1'b0});
    put(c);
    start();
    put({DEV_ADDR_DEFAULT, 1'b1});
    xfer(8'hFF, 1'b1, q, a);
    rd_byte  = q;
    rd_valid = 1'b1;
    @(posedge mclk);
    #1;
    rd_valid = 1'b0;
    stop();
  endtask : rd
endmodule : smbus_host_model
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb
  import regulator_cfg_pkg::*;
;
  localparam int TO = 200;
  logic       mclk;
  logic       rst_b;
  logic       scl_in;
  wire logic  sda_in;
  logic       host_low;
  logic       sda_out;
  logic       sda_oe;
  logic [7:0] output_setpoint_command;
  logic [7:0] voltage_identification_inputs;
  logic       fault_request;
  logic       alert_request;
  logic       fault_out;
  logic       alert_out;
  logic [2:0] light_load_phases;
  logic [2:0] active_phase_count;
  logic       digital_setpoint_select;
  logic [7:0] output_setpoint;
  logic       monitor_enable;
  logic       loop_test_enable;
  logic       write_locked;
  logic       rd_valid;
  logic [7:0] rd_byte;
  logic       nacked;
  logic [7:0] exp_q[$];
  int         n_errors = 0;
  int         checks_done = 0;
  integer     seed;
  // Open-drain line with pull-up
  assign sda_in = (host_low | sda_oe) ? 1'b0 : 1'b1;
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  regulator_mfr_config_regs #(.TIMEOUT_CYCLES(TO)) uut (
    .mclk, .rst_b, .scl_in, .sda_in, .sda_out, .sda_oe,
    .output_setpoint_command, .voltage_identification_inputs,
    .fault_request, .alert_request, .fault_out, .alert_out,
    .light_load_phases, .active_phase_count, .digital_setpoint_select,
    .output_setpoint, .monitor_enable, .loop_test_enable, .write_locked
  );
  smbus_host_model host (
    .mclk(mclk), .sda(sda_in), .scl(scl_in), .sda_low(host_low),
    .rd_valid(rd_valid), .rd_byte(rd_byte), .nacked(nacked)
  );
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_n
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(c);
  endtask : rd
  task automatic final_report();
    if (exp_q.size() != 0) begin
      n_errors++;
    end
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  // Read results against the oldest expectation
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("read_extra", 8'h00, 8'hFF);
      end else begin
        chk("read_data", exp_q.pop_front(), rd_byte);
      end
    end
  end
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    final_report();
  end
  initial begin
    int i;
    seed = 32'h787C;
    rst_b = 1'b0;
    fault_request = 1'b0;
    alert_request = 1'b0;
    output_setpoint_command = 8'h00;
    voltage_identification_inputs = 8'h00;
    wait_n(20);
    rst_b = 1'b1;
    wait_n(4);
    rd(CMD_LOCK_RESET, 8'h00);
    rd(CMD_MFR_CONFIG, 8'h07);
    rd(CMD_CONFIG_A, 8'h52);
    rd(CMD_CONFIG_B, 8'h52);
    rd(8'hE0, 8'h00);
    chk("phases", 8'h06, {5'h00, active_phase_count});
    $display("test reset values done");
    for (i = 0; i < 4; i++) begin
      host.wr(CMD_MFR_CONFIG, {i[1:0], 6'h07});
      chk("light_load", (i == 2) ? 8'h03 : (i == 1) ? 8'h02 :
          8'h01, {5'h00, light_load_phases});
    end
    for (i = 0; i < 8; i++) begin
      host.wr(CMD_MFR_CONFIG, {5'h00, i[2:0]});
      fault_request = 1'b1;
      alert_request = 1'b1;
      wait_n(3);
      chk("fault", {7'h00, i[2]}, {7'h00, fault_out});
      chk("alert", {7'h00, i[1]}, {7'h00, alert_out});
      chk("monitor", {7'h00, i[0]}, {7'h00, monitor_enable});
      fault_request = 1'b0;
      alert_request = 1'b0;
      wait_n(3);
      chk("pins_idle", 8'h00, {6'h00, fault_out, alert_out});
    end
    $display("test manufacturer bits done");
    for (i = 0; i < 8; i++) begin
      host.wr(CMD_CONFIG_A, {1'b0, i[2:0], 4'h0});
      chk("phases", 8'((i > 5) ? 6 : i + 1),
          {5'h00, active_phase_count});
    end
    output_setpoint_command = 8'($random(seed));
    voltage_identification_inputs = 8'($random(seed));
    host.wr(CMD_CONFIG_A, 8'h08);
    wait_n(4);
    chk("select", 8'h01, {7'h00, digital_setpoint_select});
    chk("setpoint", output_setpoint_command, output_setpoint);
    host.wr(CMD_CONFIG_A, 8'h00);
    wait_n(4);
    chk("setpoint", voltage_identification_inputs,
        output_setpoint);
    for (i = 0; i < 4; i++) begin
      host.wr(CMD_CONFIG_A, {5'h00, i[0], 2'h0});
      host.wr(CMD_CONFIG_B, {5'h00, i[1], 2'h0});
      chk("loop_test", {7'h00, i[0] & i[1]},
          {7'h00, loop_test_enable});
    end
    $display("test configuration done");
    host.wr(CMD_MFR_CONFIG, 8'hC1);
    host.wr(CMD_CONFIG_A, 8'h3C);
    host.wr(CMD_CONFIG_B, 8'h04);
    host.wr(CMD_LOCK_RESET, 8'h02);
    rd(CMD_MFR_CONFIG, 8'h07);
    rd(CMD_CONFIG_A, 8'h52);
    rd(CMD_CONFIG_B, 8'h52);
    rd(CMD_LOCK_RESET, 8'h00);
    $display("test soft reset done");
    host.wr(CMD_MFR_CONFIG, 8'h0F);
    host.open_addr();
    wait_n(6);
    chk("ack_drive", 8'h01, {7'h00, sda_oe});
    wait_n(TO + 20);
    chk("released", 8'h00, {7'h00, sda_oe});
    chk("sda_out", 8'h00, {7'h00, sda_out});
    host.stop();
    $display("test bus timeout done");
    host.wr(CMD_LOCK_RESET, 8'h01);
    chk("locked", 8'h01, {7'h00, write_locked});
    host.wr(CMD_MFR_CONFIG, 8'h47);
    rd(CMD_MFR_CONFIG, 8'h4F);
    host.wr(CMD_CONFIG_A, 8'h30);
    host.wr(CMD_LOCK_RESET, 8'h02);
    rd(CMD_CONFIG_A, 8'h30);
    rd(CMD_LOCK_RESET, 8'h01);
    rst_b = 1'b0;
    wait_n(20);
    rst_b = 1'b1;
    wait_n(4);
    chk("unlocked", 8'h00, {7'h00, write_locked});
    rd(CMD_MFR_CONFIG, 8'h07);
    chk("nack", 8'h00, {7'h00, nacked});
    $display("test lock done");
    wait_n(2);
    final_report();
  end
endmodule : tb
`default_nettype wire
